// ==== hw/tsit_interval_timer.sv ====
// scan interval timer with delay-timer and converter clock selection
//
// Notes on behaviour
// - touch delay inserted only when scan_interval_timer bit 7 set; resets off.
// - touch code 0 is 8 ms, codes 1..7 are 1..7 ms; reset code 4.
// - auto delay applied only when scan_interval_timer bit 3 set; resets off.
// - auto code k gives (2k+1) units of 2^26 ticks, 1.12 to 16.78 min.
// - delay used in every self-controlled mode; host mode only for XY sets.
// - delay runs from end of one data set to start of next.
// - timer clock bit 0 selects oscillator, 1 selects master clock; reset 1.
// - master clock divided by 7-bit field, zero meaning 128; reset 1.
// - delay timer clock never clocks conversions.
// - converter clock bit 0 selects oscillator, 1 master clock; reset 1.
// - converter divider N or 128; software keeps pulses above 40 ns.
// - converter and state-machine timers use converter clock, delay its own.
// - oscillator-timed delays scale with oscillator, divided by eight.
`timescale 1ns/10ps
`default_nettype none
module tsit_interval_timer #(
  parameter int TICKS_PER_MS = tsit_pkg::TICKS_PER_MS,
  parameter int MIN_UNIT_TICKS = tsit_pkg::MIN_UNIT_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic osc_in,
  input wire logic mclk_in,
  input wire logic set_done,
  input wire logic set_is_touch,
  input wire logic self_mode,
  input wire logic host_xy_set,
  output logic start_ok,
  output logic interval_busy,
  output logic conv_clk_tick,
  output logic conv_src_ext
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] scan_interval_timer;
  logic [7:0] interval_timer_clock_select;
  logic [7:0] converter_clock_select;

  wire logic hit_scan;
  wire logic hit_tclk;
  wire logic hit_cclk;
  wire logic [7:0] rd_mux;

  assign hit_scan = addr == tsit_pkg::ADDR_SCAN_INTERVAL_TIMER;
  assign hit_tclk = addr == tsit_pkg::ADDR_INTERVAL_TIMER_CLOCK_SELECT;
  assign hit_cclk = addr == tsit_pkg::ADDR_CONVERTER_CLOCK_SELECT;
  // unmapped addresses read as zero
  assign rd_mux = hit_scan ? scan_interval_timer :
                  hit_tclk ? interval_timer_clock_select :
                  hit_cclk ? converter_clock_select : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scan_interval_timer <= tsit_pkg::RST_SCAN_INTERVAL_TIMER;
      interval_timer_clock_select <= tsit_pkg::RST_INTERVAL_TIMER_CLOCK_SELECT;
      converter_clock_select <= tsit_pkg::RST_CONVERTER_CLOCK_SELECT;
      rd_data <= 8'h00;
    end else if (ce) begin
      if (wr_en && hit_scan) begin
        scan_interval_timer <= wr_data;
      end
      if (wr_en && hit_tclk) begin
        interval_timer_clock_select <= wr_data;
      end
      if (wr_en && hit_cclk) begin
        converter_clock_select <= wr_data;
      end
      if (rd_en) begin
        rd_data <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode

  wire logic touch_en;
  wire logic auto_en;
  wire logic [2:0] touch_code;
  wire logic [2:0] auto_code;
  wire logic tmr_src_ext;
  wire logic [6:0] tmr_div;
  wire logic [6:0] conv_div;

  assign touch_en = scan_interval_timer[tsit_pkg::TOUCH_DELAY_EN_BIT];
  assign auto_en = scan_interval_timer[tsit_pkg::AUTO_DELAY_EN_BIT];
  assign touch_code = scan_interval_timer[tsit_pkg::TOUCH_DELAY_CODE_LSB +: 3];
  assign auto_code = scan_interval_timer[tsit_pkg::AUTO_DELAY_CODE_LSB +: 3];
  assign tmr_src_ext = interval_timer_clock_select[tsit_pkg::CLK_SRC_EXT_BIT];
  assign tmr_div = interval_timer_clock_select[tsit_pkg::CLK_DIV_LSB +: 7];
  assign conv_div = converter_clock_select[tsit_pkg::CLK_DIV_LSB +: 7];

  ////////////////////////////////////////////////////////////////////////////
  // source edges; pins are synchronous to clk_sys, so no synchroniser.
  // limitation: both sources must stay below half of clk_sys.

  logic osc_q;
  logic mclk_q;
  wire logic osc_edge;
  wire logic mclk_edge;

  assign osc_edge = osc_in & ~osc_q;
  assign mclk_edge = mclk_in & ~mclk_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_q <= 1'b0;
      mclk_q <= 1'b0;
    end else if (ce) begin
      osc_q <= osc_in;
      mclk_q <= mclk_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dividers

  wire logic tmr_mclk_tick;
  wire logic tmr_osc_tick;
  wire logic conv_mclk_tick;

  tsit_clk_div u_tmr_mclk_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .src_edge(mclk_edge),
    .div_field(tmr_div),
    .tick(tmr_mclk_tick)
  );

  // oscillator over eight stands in for the 1 MHz tick
  tsit_clk_div u_tmr_osc_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .src_edge(osc_edge),
    .div_field(tsit_pkg::OSC_TIMER_PRESCALE),
    .tick(tmr_osc_tick)
  );

  tsit_clk_div u_conv_mclk_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .src_edge(mclk_edge),
    .div_field(conv_div),
    .tick(conv_mclk_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // converter clock, independent of the delay-timer selection

  assign conv_src_ext = converter_clock_select[tsit_pkg::CLK_SRC_EXT_BIT];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv_clk_tick <= 1'b0;
    end else if (ce) begin
      // oscillator edge registered once, so it leads the master clock tick, which the divider registers first, by one cycle
      conv_clk_tick <= conv_src_ext ? conv_mclk_tick : osc_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay targets in timer ticks

  function automatic logic [tsit_pkg::INTERVAL_CNT_W-1:0] touch_ticks(input logic [2:0] code);
    int unsigned t;
    t = (code == 3'h0) ? tsit_pkg::MS_CODE_ZERO_MS * TICKS_PER_MS
                       : 32'(code) * TICKS_PER_MS;
    touch_ticks = t[tsit_pkg::INTERVAL_CNT_W-1:0];
  endfunction : touch_ticks

  function automatic logic [tsit_pkg::INTERVAL_CNT_W-1:0] auto_ticks(input logic [2:0] code);
    int unsigned t;
    t = (32'(code) * 32'h2 + 32'h1) * MIN_UNIT_TICKS;
    auto_ticks = t[tsit_pkg::INTERVAL_CNT_W-1:0];
  endfunction : auto_ticks

  ////////////////////////////////////////////////////////////////////////////
  // interval state machine

  tsit_pkg::tsit_state_e state;
  tsit_pkg::tsit_state_e next_state;

  logic [tsit_pkg::INTERVAL_CNT_W-1:0] tick_cnt;
  logic [tsit_pkg::INTERVAL_CNT_W-1:0] target;
  logic sel_ext_q;

  wire logic timed_mode;
  wire logic delay_wanted;
  wire logic tmr_tick;
  wire logic [tsit_pkg::INTERVAL_CNT_W-1:0] cnt_inc;
  wire logic expire;
  wire logic [tsit_pkg::INTERVAL_CNT_W-1:0] next_target;

  assign timed_mode = self_mode | host_xy_set;
  assign delay_wanted = timed_mode & (set_is_touch ? touch_en : auto_en);
  assign next_target = set_is_touch ? touch_ticks(touch_code) : auto_ticks(auto_code);
  // selection latched per interval
  assign tmr_tick = sel_ext_q ? tmr_mclk_tick : tmr_osc_tick;
  assign cnt_inc = tick_cnt + 30'h00000001;
  assign expire = (state == tsit_pkg::TSIT_DELAY) && tmr_tick && (cnt_inc >= target);

  always_comb begin
    next_state = state;
    unique case (state)
      tsit_pkg::TSIT_IDLE: begin
        if (set_done && delay_wanted) begin
          next_state = tsit_pkg::TSIT_DELAY;
        end
      end
      tsit_pkg::TSIT_DELAY: begin
        if (set_done && !delay_wanted) begin
          next_state = tsit_pkg::TSIT_IDLE;
        end else if (!set_done && expire) begin
          next_state = tsit_pkg::TSIT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= tsit_pkg::TSIT_IDLE;
      tick_cnt <= 30'h00000000;
      target <= 30'h00000000;
      sel_ext_q <= tsit_pkg::RST_INTERVAL_TIMER_CLOCK_SELECT[tsit_pkg::CLK_SRC_EXT_BIT];
      start_ok <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      if (set_done) begin
        tick_cnt <= 30'h00000000;
        target <= next_target;
        sel_ext_q <= tmr_src_ext;
      end else if (state == tsit_pkg::TSIT_DELAY && tmr_tick) begin
        tick_cnt <= cnt_inc;
      end
      // no delay wanted: next set may start at once
      start_ok <= set_done ? !delay_wanted : expire;
    end
  end

  assign interval_busy = state == tsit_pkg::TSIT_DELAY;

endmodule : tsit_interval_timer
`default_nettype wire

// ==== inc/tsit_pkg.sv ====
// constants and helpers shared by the scan interval timer
package tsit_pkg;

  // register offsets on the 8-bit register port
  localparam logic [7:0] ADDR_SCAN_INTERVAL_TIMER = 8'h0F;
  localparam logic [7:0] ADDR_INTERVAL_TIMER_CLOCK_SELECT = 8'h10;
  localparam logic [7:0] ADDR_CONVERTER_CLOCK_SELECT = 8'h11;

  // reset values
  localparam logic [7:0] RST_SCAN_INTERVAL_TIMER = 8'h40;
  localparam logic [7:0] RST_INTERVAL_TIMER_CLOCK_SELECT = 8'h81;
  localparam logic [7:0] RST_CONVERTER_CLOCK_SELECT = 8'h81;

  // scan_interval_timer fields
  localparam int TOUCH_DELAY_EN_BIT = 7;
  localparam int TOUCH_DELAY_CODE_LSB = 4;
  localparam int AUTO_DELAY_EN_BIT = 3;
  localparam int AUTO_DELAY_CODE_LSB = 0;
  localparam int DELAY_CODE_W = 3;

  // clock select register fields (same layout in both)
  localparam int CLK_SRC_EXT_BIT = 7;
  localparam int CLK_DIV_LSB = 0;
  localparam int CLK_DIV_W = 7;

  // timing
  localparam int CLK_SYS_PERIOD_NS = 40;
  localparam int CONV_MIN_PULSE_NS = 40;
  localparam logic [6:0] OSC_TIMER_PRESCALE = 7'h08;
  localparam int TICKS_PER_MS = 1000;
  localparam int MS_CODE_ZERO_MS = 8;
  localparam int MIN_UNIT_TICKS = 67108864;
  localparam int INTERVAL_CNT_W = 30;
  localparam int RATIO_W = 8;

  typedef enum logic [0:0] {
    TSIT_IDLE = 1'b0,
    TSIT_DELAY = 1'b1
  } tsit_state_e;

  // divider field: N divides by N, zero divides by 128
  function automatic logic [RATIO_W-1:0] div_ratio(input logic [CLK_DIV_W-1:0] field);
    div_ratio = (field == 7'h00) ? 8'h80 : {1'b0, field};
  endfunction : div_ratio

endpackage : tsit_pkg

// ==== hw/tsit_clk_div.sv ====
// clock-enable divider counting rising edges of a sampled source
`timescale 1ns/10ps
`default_nettype none
module tsit_clk_div (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic src_edge,
  input wire logic [6:0] div_field,
  output logic tick
);

  logic [tsit_pkg::RATIO_W-1:0] cnt;
  wire logic [tsit_pkg::RATIO_W-1:0] ratio;
  wire logic [tsit_pkg::RATIO_W-1:0] cnt_inc;
  wire logic wrap;

  assign ratio = tsit_pkg::div_ratio(div_field);
  assign cnt_inc = cnt + 8'h01;
  // >= so a ratio lowered mid-count still wraps at once
  assign wrap = cnt_inc >= ratio;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else if (ce) begin
      tick <= src_edge & wrap;
      if (src_edge) begin
        cnt <= wrap ? 8'h00 : cnt_inc;
      end
    end
  end

endmodule : tsit_clk_div
`default_nettype wire

// ==== dv/tsit_sva.sv ====
// port assertions for the scan interval timer
`timescale 1ns/10ps
`default_nettype none
module tsit_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic set_done,
  input wire logic self_mode,
  input wire logic host_xy_set,
  input wire logic start_ok,
  input wire logic interval_busy,
  input wire logic conv_clk_tick,
  input wire logic conv_src_ext
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_busy_end_start: assert property ($fell(interval_busy) && !$past(rst) |-> start_ok)
    else $error("busy fell without start");
  // ce low freezes the pulse, so only a running cycle must clear it
  a_start_pulse: assert property (ce && start_ok |=> !start_ok)
    else $error("start_ok longer than one cycle");
  a_start_idle: assert property (start_ok |-> !interval_busy)
    else $error("start_ok while busy");
  a_mode_nodelay: assert property (ce && set_done && !self_mode && !host_xy_set
    |=> start_ok && !interval_busy)
    else $error("delay outside scan modes");
  a_wr_rd_back: assert property (ce && wr_en && addr == 8'h0F ##1 !(ce && wr_en)
    ##1 ce && rd_en && !wr_en && addr == 8'h0F |=> rd_data == $past(wr_data, 3))
    else $error("read back mismatch");
  a_unmapped_rd: assert property (ce && rd_en && (addr < 8'h0F || addr > 8'h11)
    |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!(ce && rd_en) |=> $stable(rd_data))
    else $error("rd_data moved without read");
  a_conv_src_wr: assert property (ce && wr_en && addr == 8'h11
    |=> conv_src_ext == $past(wr_data[7]))
    else $error("converter source not updated");
  a_tick_pulse: assert property (ce && conv_clk_tick |=> !conv_clk_tick)
    else $error("converter tick too long");
  c_delay_end: cover property ($fell(interval_busy) && start_ok);
  c_restart: cover property (interval_busy && set_done);
  c_conv_tick: cover property (conv_clk_tick && !conv_src_ext);
endmodule : tsit_sva
bind tsit_interval_timer tsit_sva tsit_sva_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
  .set_done(set_done), .self_mode(self_mode), .host_xy_set(host_xy_set),
  .start_ok(start_ok), .interval_busy(interval_busy), .conv_clk_tick(conv_clk_tick),
  .conv_src_ext(conv_src_ext));
`default_nettype wire

// ==== dv/tb.sv ====
// self-checking bench for the scan interval timer
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int TPM = 4;
  localparam int MUT = 8;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic osc_in = 1'b0;
  logic mclk_in = 1'b0;
  logic set_done = 1'b0;
  logic set_is_touch = 1'b0;
  logic self_mode = 1'b1;
  logic host_xy_set = 1'b0;
  logic [7:0] rd_data;
  logic start_ok, interval_busy, conv_clk_tick, conv_src_ext;
  int err_count = 0;
  int check_count = 0;
  int phase = 0;
  always #20 clk_sys = ~clk_sys;
  // master clock period 4 cycles, oscillator 6 cycles, both below the sampling limit
  always @(negedge clk_sys) begin
    phase <= phase + 1;
    mclk_in <= (phase % 4) >= 2;
    osc_in <= (phase % 6) >= 3;
  end
  tsit_interval_timer #(.TICKS_PER_MS(TPM), .MIN_UNIT_TICKS(MUT)) tsit_interval_timer_i (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .osc_in(osc_in), .mclk_in(mclk_in),
    .set_done(set_done), .set_is_touch(set_is_touch), .self_mode(self_mode),
    .host_xy_set(host_xy_set), .start_ok(start_ok), .interval_busy(interval_busy),
    .conv_clk_tick(conv_clk_tick), .conv_src_ext(conv_src_ext));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : cmp_rng
  // callers sit at a falling edge; one idle cycle after each access so that
  // a strobe is never lowered and raised again in one time step
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk_sys);
    wr_en = 1'b0;
    @(negedge clk_sys);
  endtask : reg_wr
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk_sys);
    rd_en = 1'b0;
    cmp8(rd_data, exp);
    @(negedge clk_sys);
  endtask : chk_rd
  // cycles from set_done to start_ok; 1 means no delay
  task automatic run_set(input logic tch, input logic slf, input logic hxy, output int n);
    set_is_touch = tch;
    self_mode = slf;
    host_xy_set = hxy;
    set_done = 1'b1;
    @(negedge clk_sys);
    set_done = 1'b0;
    n = 1;
    while (start_ok !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
  endtask : run_set
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    chk_rd(8'h0F, 8'h40);
    chk_rd(8'h10, 8'h81);
    chk_rd(8'h11, 8'h81);
    chk_rd(8'h12, 8'h00);
    reg_wr(8'h0F, 8'h5A);
    chk_rd(8'h0F, 8'h5A);
    ce = 1'b0;
    reg_wr(8'h0F, 8'hA5);
    ce = 1'b1;
    chk_rd(8'h0F, 8'h5A);
  endtask : t_regs
  task automatic t_delays();
    logic [7:0] sit[7] = '{8'h80, 8'h90, 8'hF0, 8'h90, 8'h90, 8'h08, 8'h0F};
    logic [7:0] tcs[7] = '{8'h81, 8'h82, 8'h81, 8'h80, 8'h01, 8'h81, 8'h81};
    int tk[7] = '{8 * TPM, TPM, 7 * TPM, TPM, TPM, MUT, 15 * MUT};
    int pc[7] = '{4, 8, 4, 512, 48, 4, 4};
    int n;
    for (int i = 0; i < 7; i++) begin
      reg_wr(8'h0F, sit[i]);
      reg_wr(8'h10, tcs[i]);
      run_set(i < 5, 1'b1, 1'b0, n);
      cmp_rng(n, (tk[i] - 1) * pc[i], tk[i] * pc[i] + 4);
    end
  endtask : t_delays
  task automatic t_gate();
    int n;
    reg_wr(8'h0F, 8'h80);
    run_set(1'b0, 1'b1, 1'b0, n);
    cmp_rng(n, 1, 1);
    reg_wr(8'h0F, 8'h08);
    run_set(1'b1, 1'b1, 1'b0, n);
    cmp_rng(n, 1, 1);
    reg_wr(8'h0F, 8'h90);
    reg_wr(8'h10, 8'h81);
    run_set(1'b1, 1'b0, 1'b0, n);
    cmp_rng(n, 1, 1);
    run_set(1'b1, 1'b0, 1'b1, n);
    cmp_rng(n, 3 * TPM, 4 * TPM + 4);
    set_done = 1'b1;
    @(negedge clk_sys);
    set_done = 1'b0;
    repeat (8) @(negedge clk_sys);
    cmp8({7'h00, interval_busy}, 8'h01);
    run_set(1'b1, 1'b1, 1'b0, n);
    cmp_rng(n, 3 * TPM, 4 * TPM + 4);
  endtask : t_gate
  task automatic t_conv();
    // divider zero means 128: at most one tick in the window
    logic [7:0] cv[4] = '{8'h81, 8'h82, 8'h01, 8'h80};
    int ex[4] = '{24, 12, 16, 0};
    int n;
    reg_wr(8'h10, 8'h01);
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'h11, cv[i]);
      cmp8({7'h00, conv_src_ext}, {7'h00, cv[i][7]});
      n = 0;
      repeat (96) begin
        @(negedge clk_sys);
        if (conv_clk_tick === 1'b1) n++;
      end
      cmp_rng(n, ex[i] - 1, ex[i] + 1);
    end
  endtask : t_conv
  ////////////////////////////////////////////////////////////////////////////////
  // run needs about 3500 cycles; allow a wide margin
  initial begin
    #(40 * 30000);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    t_regs();
    t_delays();
    t_gate();
    t_conv();
    complete_run();
  end
endmodule : tb
`default_nettype wire
